// ===== pkg/mode_irq_pkg.sv
// Shared constants and carriers of the mode and interrupt-enable block.
// Assumes an 8-bit register port with byte-wide offsets.
`default_nettype none

package mode_irq_pkg;

    // Register offsets
    localparam logic [7:0] IE2_OFFSET   = 8'h06;
    localparam logic [7:0] MODE1_OFFSET = 8'h07;
    localparam logic [7:0] MODE2_OFFSET = 8'h08;

    // Interrupt-enable two: upper nibble read-only, lower nibble writable
    localparam int         IE2_RW_HI    = 3;
    localparam logic [3:0] IE2_RW_RESET = 4'h0;
    localparam logic [3:0] IE2_RO_VALUE = 4'hF;

    // Operating mode one fields
    localparam int         SWRES_BIT    = 7;
    localparam int         LBD_EN_BIT   = 6;
    localparam int         WUT_EN_BIT   = 5;
    localparam int         LF_SEL_BIT   = 4;
    localparam int         TX_ON_BIT    = 3;
    localparam int         RX_ON_BIT    = 2;
    localparam int         SYNTH_ON_BIT = 1;
    localparam int         XTAL_ON_BIT  = 0;
    localparam logic [7:0] MODE1_RESET  = 8'h01;

    // Operating mode two fields
    localparam int         ANT_HI_BIT   = 7;
    localparam int         ANT_LO_BIT   = 5;
    localparam int         RX_MULTI_BIT = 4;
    localparam int         AUTO_TX_BIT  = 3;
    localparam int         LOW_DUTY_BIT = 2;
    localparam int         CLR_RX_BIT   = 1;
    localparam int         CLR_TX_BIT   = 0;
    localparam logic [7:0] MODE2_RESET  = 8'h00;

    // Antenna field codes
    localparam logic [2:0] ANT_FIX_A_LOW   = 3'h0;
    localparam logic [2:0] ANT_FIX_B_LOW   = 3'h1;
    localparam logic [2:0] ANT_FIX_A_HIGH  = 3'h2;
    localparam logic [2:0] ANT_FIX_B_HIGH  = 3'h3;
    localparam logic [2:0] ANT_ALGO_LOW    = 3'h4;
    localparam logic [2:0] ANT_ALGO_HIGH   = 3'h5;
    localparam logic [2:0] ANT_BEACON_LOW  = 3'h6;
    localparam logic [2:0] ANT_BEACON_HIGH = 3'h7;

    // Interrupt events, bit 7 down to bit 0 as in the enable register
    typedef struct packed {
        logic sync_word;
        logic preamble_valid;
        logic preamble_invalid;
        logic rssi_above;
        logic wut_expired;
        logic low_battery;
        logic module_ready;
        logic power_on;
    } irq_evt_t;

    // Status from the radio datapath
    typedef struct packed {
        logic fifo_mode;
        logic rx_pkt_handling;
        logic packet_sent;
        logic valid_packet;
        logic tx_almost_full;
        logic tx_fifo_empty;
    } radio_status_t;

    // Mode controls towards the radio
    typedef struct packed {
        logic lbd_on;
        logic wut_on;
        logic lf_osc_sel;
        logic tx_on;
        logic rx_on;
        logic synth_idle_on;
        logic xtal_on;
        logic low_duty_on;
    } mode_ctrl_t;

endpackage

`default_nettype wire

// ===== hdl/antenna_select_decode.sv
// Combinational decode of the antenna field into two select levels.
// Assumes the caller registers the outputs.
`default_nettype none

module antenna_select_decode (
    input  wire logic [2:0] code_i,
    input  wire logic       in_rxtx_i,
    input  wire logic       algo_pick_i,
    output logic            ant1_o,
    output logic            ant2_o,
    output logic            algo_on_o,
    output logic            beacon_o
);

    always_comb begin
        ant1_o    = 1'b0;
        ant2_o    = 1'b0;
        algo_on_o = 1'b0;
        beacon_o  = 1'b0;
        case (code_i)
            mode_irq_pkg::ANT_FIX_A_LOW, mode_irq_pkg::ANT_FIX_A_HIGH: begin
                ant1_o = 1'b0;
                ant2_o = in_rxtx_i;
                if (!in_rxtx_i && code_i == mode_irq_pkg::ANT_FIX_A_HIGH) begin
                    ant1_o = 1'b1;
                    ant2_o = 1'b1;
                end
            end
            mode_irq_pkg::ANT_FIX_B_LOW, mode_irq_pkg::ANT_FIX_B_HIGH: begin
                ant1_o = in_rxtx_i;
                ant2_o = 1'b0;
                if (!in_rxtx_i && code_i == mode_irq_pkg::ANT_FIX_B_HIGH) begin
                    ant1_o = 1'b1;
                    ant2_o = 1'b1;
                end
            end
            default: begin
                // Algorithm codes: pick steers in RX/TX, code bit 0 idles
                algo_on_o = 1'b1;
                beacon_o  = code_i[1];
                if (in_rxtx_i) begin
                    ant1_o = algo_pick_i;
                    ant2_o = ~algo_pick_i;
                end else begin
                    ant1_o = code_i[0];
                    ant2_o = code_i[0];
                end
            end
        endcase
    end

endmodule

`default_nettype wire

// ===== hdl/mode_and_irq_enable_control.sv
// Interrupt-enable two and operating-mode one/two registers with their
// effects on the radio, the interrupt output and the antenna selects.
// Assumes a synchronous register port and radio status pulses on clk_i.
//
// The address-and-strobe port was decided locally.
`default_nettype none

module mode_and_irq_enable_control (
    input  wire logic                        clk_i,
    input  wire logic                        rst_n_i,
    input  wire logic [7:0]                  addr_i,
    input  wire logic [7:0]                  wdata_i,
    input  wire logic                        wr_i,
    input  wire logic                        rd_i,
    output logic      [7:0]                  rdata_o,
    input  wire mode_irq_pkg::irq_evt_t      evt_i,
    input  wire mode_irq_pkg::radio_status_t status_i,
    input  wire logic                        algo_pick_i,
    output logic                             irq_o,
    output mode_irq_pkg::mode_ctrl_t         ctrl_o,
    output logic                             soft_reset_o,
    output logic                             rx_fifo_clear_o,
    output logic                             tx_fifo_clear_o,
    output logic                             ant1_o,
    output logic                             ant2_o,
    output logic                             algo_on_o,
    output logic                             beacon_o
);

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a == o);
    endfunction

    logic [3:0]               ie2_lo_q;
    logic [3:0]               ie2_lo_d;
    logic [7:0]               mode1_q;
    logic [7:0]               mode1_d;
    logic [7:0]               mode2_q;
    logic [7:0]               mode2_d;
    logic                     auto_tx_q;
    logic                     auto_tx_d;
    logic [7:0]               rdata_q;
    logic [7:0]               rdata_d;
    logic                     irq_q;
    logic                     irq_d;
    mode_irq_pkg::mode_ctrl_t ctrl_q;
    mode_irq_pkg::mode_ctrl_t ctrl_d;
    logic                     soft_rst_q;
    logic                     soft_rst_d;
    logic                     rx_clr_q;
    logic                     rx_clr_d;
    logic                     tx_clr_q;
    logic                     tx_clr_d;
    logic                     ant1_q;
    logic                     ant2_q;
    logic                     algo_on_q;
    logic                     beacon_q;
    logic                     ant1_c;
    logic                     ant2_c;
    logic                     algo_on_c;
    logic                     beacon_c;
    logic [7:0]               enables;
    logic [7:0]               gated_evt;
    logic                     rx_stays;

    assign enables = {mode_irq_pkg::IE2_RO_VALUE, ie2_lo_q};

    // Detector and timer events only count while those blocks run
    always_comb begin
        gated_evt = evt_i;
        gated_evt[2] = evt_i.low_battery & mode1_q[mode_irq_pkg::LBD_EN_BIT];
        gated_evt[3] = evt_i.wut_expired & mode1_q[mode_irq_pkg::WUT_EN_BIT];
    end

    assign rx_stays = mode2_q[mode_irq_pkg::RX_MULTI_BIT]
                    & status_i.fifo_mode & status_i.rx_pkt_handling;

    always_comb begin
        ie2_lo_d   = ie2_lo_q;
        mode1_d    = mode1_q;
        mode2_d    = mode2_q;
        auto_tx_d  = auto_tx_q;
        soft_rst_d = 1'b0;
        rx_clr_d   = 1'b0;
        tx_clr_d   = 1'b0;

        // Hardware clears first so a host write in the same cycle wins
        if (status_i.fifo_mode && status_i.packet_sent) begin
            mode1_d[mode_irq_pkg::TX_ON_BIT] = 1'b0;
        end
        if (status_i.valid_packet && !rx_stays) begin
            mode1_d[mode_irq_pkg::RX_ON_BIT] = 1'b0;
        end
        if (!mode2_q[mode_irq_pkg::AUTO_TX_BIT]
            || status_i.tx_fifo_empty) begin
            auto_tx_d = 1'b0;
        end else if (status_i.tx_almost_full) begin
            auto_tx_d = 1'b1;
        end

        if (wr_i) begin
            if (hit(addr_i, mode_irq_pkg::IE2_OFFSET)) begin
                ie2_lo_d = wdata_i[mode_irq_pkg::IE2_RW_HI:0];
            end else if (hit(addr_i, mode_irq_pkg::MODE1_OFFSET)) begin
                if (wdata_i[mode_irq_pkg::SWRES_BIT]) begin
                    // Reset bit is never stored, so it reads back as zero
                    ie2_lo_d   = mode_irq_pkg::IE2_RW_RESET;
                    mode1_d    = mode_irq_pkg::MODE1_RESET;
                    mode2_d    = mode_irq_pkg::MODE2_RESET;
                    auto_tx_d  = 1'b0;
                    soft_rst_d = 1'b1;
                end else begin
                    // Clearing the TX bit is how the host aborts a send, except one held by auto_tx_d
                    mode1_d = {1'b0, wdata_i[6:0]};
                end
            end else if (hit(addr_i, mode_irq_pkg::MODE2_OFFSET)) begin
                mode2_d  = wdata_i;
                // Only a 1 then 0 pair empties a FIFO
                rx_clr_d = mode2_q[mode_irq_pkg::CLR_RX_BIT]
                         & ~wdata_i[mode_irq_pkg::CLR_RX_BIT];
                tx_clr_d = mode2_q[mode_irq_pkg::CLR_TX_BIT]
                         & ~wdata_i[mode_irq_pkg::CLR_TX_BIT];
            end
        end
    end

    always_comb begin
        ctrl_d.lbd_on        = mode1_d[mode_irq_pkg::LBD_EN_BIT];
        ctrl_d.wut_on        = mode1_d[mode_irq_pkg::WUT_EN_BIT];
        ctrl_d.lf_osc_sel    = mode1_d[mode_irq_pkg::LF_SEL_BIT];
        ctrl_d.tx_on         = mode1_d[mode_irq_pkg::TX_ON_BIT]
                             | auto_tx_d;
        ctrl_d.rx_on         = mode1_d[mode_irq_pkg::RX_ON_BIT];
        ctrl_d.synth_idle_on =
            mode1_d[mode_irq_pkg::SYNTH_ON_BIT];
        ctrl_d.xtal_on       = mode1_d[mode_irq_pkg::XTAL_ON_BIT];
        ctrl_d.low_duty_on   = mode2_d[mode_irq_pkg::LOW_DUTY_BIT];
    end

    // One level for all enabled events; status bits live elsewhere
    always_comb begin
        irq_d = |(gated_evt
                  & enables);
    end

    always_comb begin
        rdata_d = 8'h00;
        if (rd_i) begin
            if (hit(addr_i, mode_irq_pkg::IE2_OFFSET)) begin
                rdata_d = enables;
            end else if (hit(addr_i, mode_irq_pkg::MODE1_OFFSET)) begin
                rdata_d = mode1_q;
            end else if (hit(addr_i, mode_irq_pkg::MODE2_OFFSET)) begin
                rdata_d = mode2_q;
            end
        end
    end

    // Pin setup for diversity is the host's job; decode trusts it
    antenna_select_decode u_ant (
        .code_i      (mode2_q[mode_irq_pkg::ANT_HI_BIT:
                              mode_irq_pkg::ANT_LO_BIT]),
        .in_rxtx_i   (ctrl_q.tx_on | ctrl_q.rx_on),
        .algo_pick_i (algo_pick_i),
        .ant1_o      (ant1_c),
        .ant2_o      (ant2_c),
        .algo_on_o   (algo_on_c),
        .beacon_o    (beacon_c)
    );

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ie2_lo_q   <= mode_irq_pkg::IE2_RW_RESET;
            mode1_q    <= mode_irq_pkg::MODE1_RESET;
            mode2_q    <= mode_irq_pkg::MODE2_RESET;
            auto_tx_q  <= 1'b0;
            rdata_q    <= 8'h00;
            irq_q      <= 1'b0;
            ctrl_q     <= '0;
            soft_rst_q <= 1'b0;
            rx_clr_q   <= 1'b0;
            tx_clr_q   <= 1'b0;
            ant1_q     <= 1'b0;
            ant2_q     <= 1'b0;
            algo_on_q  <= 1'b0;
            beacon_q   <= 1'b0;
        end else begin
            ie2_lo_q   <= ie2_lo_d;
            mode1_q    <= mode1_d;
            mode2_q    <= mode2_d;
            auto_tx_q  <= auto_tx_d;
            rdata_q    <= rdata_d;
            irq_q      <= irq_d;
            ctrl_q     <= ctrl_d;
            soft_rst_q <= soft_rst_d;
            rx_clr_q   <= rx_clr_d;
            tx_clr_q   <= tx_clr_d;
            ant1_q     <= ant1_c;
            ant2_q     <= ant2_c;
            algo_on_q  <= algo_on_c;
            beacon_q   <= beacon_c;
        end
    end

    assign rdata_o         = rdata_q;
    assign irq_o           = irq_q;
    assign ctrl_o          = ctrl_q;
    assign soft_reset_o    = soft_rst_q;
    assign rx_fifo_clear_o = rx_clr_q;
    assign tx_fifo_clear_o = tx_clr_q;
    assign ant1_o          = ant1_q;
    assign ant2_o          = ant2_q;
    assign algo_on_o       = algo_on_q;
    assign beacon_o        = beacon_q;

endmodule

`default_nettype wire

// ===== verification/mode_irq_assertions.sv
// Port-level checker for the mode and interrupt-enable block.
// Assumes one clock domain and the byte register port of the block.
`default_nettype none

module mode_irq_assertions (
    input wire logic                     clk_i,
    input wire logic                     rst_n_i,
    input wire logic [7:0]               addr_i,
    input wire logic [7:0]               wdata_i,
    input wire logic                     wr_i,
    input wire logic                     rd_i,
    input wire logic [7:0]               rdata_o,
    input wire mode_irq_pkg::irq_evt_t   evt_i,
    input wire logic                     irq_o,
    input wire mode_irq_pkg::mode_ctrl_t ctrl_o,
    input wire logic                     soft_reset_o,
    input wire logic                     rx_fifo_clear_o,
    input wire logic                     algo_on_o,
    input wire logic                     beacon_o
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] M1 = mode_irq_pkg::MODE1_OFFSET;
    localparam logic [7:0] M2 = mode_irq_pkg::MODE2_OFFSET;

    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_soft_wr;
        wr_i && addr_i == M1 && wdata_i[7];
    endsequence

    sequence s_ant_wr;
        wr_i && addr_i == M2;
    endsequence

    a_read_gap:
        assert property (!$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data outside its cycle");
    a_upper_fixed:
        assert property (rd_i && addr_i == mode_irq_pkg::IE2_OFFSET
            |=> rdata_o[7:4] == 4'hF) else $error("enable top nibble");
    a_reset_bit_zero:
        assert property (rd_i && addr_i == M1 |=> !rdata_o[7])
        else $error("reset bit read back set");
    a_soft_defaults:
        assert property (s_soft_wr |=> soft_reset_o && ctrl_o == 8'h02)
        else $error("soft reset defaults");
    a_mode_write:
        assert property (wr_i && addr_i == M1 && !wdata_i[7] |=>
            {ctrl_o.lbd_on, ctrl_o.wut_on, ctrl_o.lf_osc_sel, ctrl_o.rx_on,
             ctrl_o.synth_idle_on, ctrl_o.xtal_on}
            == {$past(wdata_i[6:4]), $past(wdata_i[2:0])})
        else $error("mode controls differ from write");
    a_irq_cause:
        assert property (irq_o |-> $past(evt_i) != 8'h00)
        else $error("interrupt without event");
    a_clear_pair:
        assert property (rx_fifo_clear_o |-> $past(wr_i)
            && $past(addr_i) == M2 && !$past(wdata_i[1]))
        else $error("clear pulse without zero write");
    a_ant_follow:
        assert property (s_ant_wr |=> ##1
            algo_on_o == $past(wdata_i[7], 2)
            && beacon_o == ($past(wdata_i[7], 2) && $past(wdata_i[6], 2)))
        else $error("antenna mode flags");
endmodule

bind mode_and_irq_enable_control mode_irq_assertions mode_irq_assertions_inst (
    .clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .evt_i,
    .irq_o, .ctrl_o, .soft_reset_o, .rx_fifo_clear_o, .algo_on_o, .beacon_o);

`default_nettype wire

// ===== verification/radio_partner.sv
// Behavioural radio datapath feeding status back to the block.
// Assumes the bench sets the FIFO mode, packet handling and fill level.
`default_nettype none

module radio_partner (
    input  wire logic                     clk_i,
    input  wire logic                     rst_n_i,
    input  wire mode_irq_pkg::mode_ctrl_t ctrl_i,
    input  wire logic                     fifo_mode_i,
    input  wire logic                     pkt_rx_i,
    input  wire logic                     fill_i,
    output mode_irq_pkg::radio_status_t   status_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] tx_cnt_q;
    logic [2:0] tx_cnt_d;
    logic [2:0] rx_cnt_q;
    logic [2:0] rx_cnt_d;

    // A packet ends every eight cycles while the radio stays on
    always_comb begin
        tx_cnt_d = ctrl_i.tx_on ? tx_cnt_q + 3'h1 : 3'h0;
        rx_cnt_d = ctrl_i.rx_on ? rx_cnt_q + 3'h1 : 3'h0;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_cnt_q <= 3'h0;
            rx_cnt_q <= 3'h0;
        end else begin
            tx_cnt_q <= tx_cnt_d;
            rx_cnt_q <= rx_cnt_d;
        end
    end

    assign status_o = {fifo_mode_i, pkt_rx_i, tx_cnt_q == 3'h3,
                       rx_cnt_q == 3'h3, fill_i, !fill_i};
endmodule

`default_nettype wire

// ===== verification/tb_mode_and_irq_enable_control.sv
// Self-checking bench for the mode and interrupt-enable block.
// Assumes the radio partner model and the bound checker.
`default_nettype none

module tb_mode_and_irq_enable_control;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] IE = mode_irq_pkg::IE2_OFFSET;
    localparam logic [7:0] M1 = mode_irq_pkg::MODE1_OFFSET;
    localparam logic [7:0] M2 = mode_irq_pkg::MODE2_OFFSET;
    logic                        clk_i = 1'b0;
    logic                        rst_n_i = 1'b0;
    logic [7:0]                  addr_i = 8'h00;
    logic [7:0]                  wdata_i = 8'h00;
    logic                        wr_i = 1'b0;
    logic                        rd_i = 1'b0;
    logic                        algo_pick_i = 1'b0;
    logic                        fifo_mode = 1'b0;
    logic                        pkt_rx = 1'b0;
    logic                        fill = 1'b0;
    mode_irq_pkg::irq_evt_t      evt_i = '0;
    mode_irq_pkg::radio_status_t status_i;
    mode_irq_pkg::mode_ctrl_t    ctrl_o;
    logic [7:0]                  rdata_o;
    logic                        irq_o;
    logic                        soft_reset_o;
    logic                        rx_fifo_clear_o;
    logic                        tx_fifo_clear_o;
    logic                        ant1_o;
    logic                        ant2_o;
    logic                        algo_on_o;
    logic                        beacon_o;
    int                          fails = 0;
    int                          compares = 0;
    int                          cycles = 0;

    mode_and_irq_enable_control mode_and_irq_enable_control_inst (
        .clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .evt_i,
        .status_i, .algo_pick_i, .irq_o, .ctrl_o, .soft_reset_o,
        .rx_fifo_clear_o, .tx_fifo_clear_o, .ant1_o, .ant2_o, .algo_on_o,
        .beacon_o);

    radio_partner radio_partner_inst (
        .clk_i, .rst_n_i, .ctrl_i(ctrl_o), .fifo_mode_i(fifo_mode),
        .pkt_rx_i(pkt_rx), .fill_i(fill), .status_o(status_i));

    always #2 clk_i = ~clk_i;

    task automatic complete_run;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Far beyond the few hundred cycles the sequence needs
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            complete_run();
        end
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: %0h, expected %0h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
        #1;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        chk(rdata_o, e);
    endtask

    task automatic ev(input int i, input logic e);
        @(posedge clk_i);
        evt_i <= 8'h01 << i;
        @(posedge clk_i);
        evt_i <= '0;
        #1;
        chk({7'h00, irq_o}, {7'h00, e});
        @(posedge clk_i);
        #1;
        chk({7'h00, irq_o}, 8'h00);
    endtask

    // Pick follows code bit 1 in the loop below
    function automatic logic [7:0] ant_exp(input logic [2:0] c,
                                           input logic       on);
        logic [1:0] s;
        if (!on) s = c[2] ? {2{c[0]}} : {2{c[1]}};
        else if (c[2]) s = c[1] ? 2'b10 : 2'b01;
        else s = c[0] ? 2'b10 : 2'b01;
        return {4'h0, s, c[2], c[2] & c[1]};
    endfunction

    task automatic chk_ant(input logic [2:0] c, input logic on);
        chk({4'h0, ant1_o, ant2_o, algo_on_o, beacon_o}, ant_exp(c, on));
    endtask

    initial begin
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rdc(IE, 8'hF0);
        rdc(M1, 8'h01);
        rdc(M2, 8'h00);
        rdc(8'h10, 8'h00);
        wr(IE, 8'hFF);
        rdc(IE, 8'hFF);
        wr(M1, 8'h5E);
        chk(ctrl_o, 8'hBC);
        repeat (6) @(posedge clk_i);
        rdc(M1, 8'h5A);
        wr(M1, 8'h61);
        for (int i = 0; i < 8; i++) begin
            wr(IE, 8'h00);
            ev(i, i > 3);
            wr(IE, 8'h01 << i);
            ev(i, 1'b1);
        end
        wr(M1, 8'h01);
        wr(IE, 8'h0F);
        rdc(IE, 8'hFF);
        ev(2, 1'b0);
        ev(3, 1'b0);
        @(posedge clk_i);
        fifo_mode <= 1'b1;
        wr(M1, 8'h09);
        repeat (8) @(posedge clk_i);
        rdc(M1, 8'h01);
        @(posedge clk_i);
        pkt_rx <= 1'b1;
        wr(M2, 8'h10);
        wr(M1, 8'h05);
        repeat (10) @(posedge clk_i);
        rdc(M1, 8'h05);
        wr(M2, 8'h00);
        repeat (10) @(posedge clk_i);
        rdc(M1, 8'h01);
        wr(M2, 8'h08);
        @(posedge clk_i);
        fill <= 1'b1;
        repeat (3) @(posedge clk_i);
        #1;
        chk({7'h00, ctrl_o.tx_on}, 8'h01);
        @(posedge clk_i);
        fill <= 1'b0;
        repeat (3) @(posedge clk_i);
        #1;
        chk({7'h00, ctrl_o.tx_on}, 8'h00);
        @(posedge clk_i);
        fifo_mode <= 1'b0;
        pkt_rx <= 1'b0;
        wr(M2, 8'h03);
        wr(M2, 8'h00);
        chk({6'h00, rx_fifo_clear_o, tx_fifo_clear_o}, 8'h03);
        @(posedge clk_i);
        #1;
        chk({6'h00, rx_fifo_clear_o, tx_fifo_clear_o}, 8'h00);
        // Diversity pins taken as set up by the host
        for (int c = 0; c < 8; c++) begin
            @(posedge clk_i);
            algo_pick_i <= c[1];
            // Clearing the TX bit aborts a running send
            wr(M1, 8'h01);
            chk({7'h00, ctrl_o.tx_on}, 8'h00);
            wr(M2, 8'(c << 5));
            @(posedge clk_i);
            #1;
            chk_ant(3'(c), 1'b0);
            wr(M1, 8'h09);
            repeat (2) @(posedge clk_i);
            #1;
            chk_ant(3'(c), 1'b1);
        end
        wr(M2, 8'h1C);
        chk(ctrl_o, 8'h13);
        wr(M1, 8'h80);
        chk({7'h00, soft_reset_o}, 8'h01);
        rdc(M2, 8'h00);
        rdc(M1, 8'h01);
        rdc(IE, 8'hF0);
        complete_run();
    end
endmodule

`default_nettype wire
